// >>> rtl/dalc_pkg.sv
// Package for the audio, link and equalizer control register bank.
// Assumes an 8-bit register address space reached through the device's
// serial control port, with all logic on the single ref_clk domain.
package dalc_pkg;

  // Register offsets.
  localparam logic [7:0] AUDIO_SERIAL_CONTROL_OFS    = 8'h2b;
  localparam logic [7:0] PIXEL_CLOCK_TEST_SELECT_OFS = 8'h2e;
  localparam logic [7:0] DUAL_RECEIVE_CONTROL_OFS    = 8'h34;
  localparam logic [7:0] EQUALIZER_TEST_CONTROL_OFS  = 8'h35;

  // Reset values.
  localparam logic [7:0] AUDIO_SERIAL_CONTROL_RST    = 8'h00;
  localparam logic [7:0] PIXEL_CLOCK_TEST_SELECT_RST = 8'h00;
  localparam logic [7:0] DUAL_RECEIVE_CONTROL_RST    = 8'h01;
  localparam logic [7:0] EQUALIZER_TEST_CONTROL_RST  = 8'h00;

  // Audio serial control fields.
  localparam int AUD_OVERRUN_BIT   = 3;
  localparam int AUD_UNDERRUN_BIT  = 2;
  localparam int AUD_ERR_CLEAR_BIT = 1;
  localparam int AUD_EDGE_BIT      = 0;

  // Pixel clock test select field.
  localparam int PCLK_TEST_BIT = 7;

  // Dual receive control fields.
  localparam int RX_LOCK_MODE_BIT   = 6;
  localparam int RAW_BACKCH_BIT     = 5;
  localparam int INPUT_MODE_HI_BIT  = 4;
  localparam int INPUT_MODE_LO_BIT  = 3;
  localparam int SECOND_PORT_BIT    = 1;
  localparam int FIRST_PORT_BIT     = 0;

  // Equalizer test control fields.
  localparam int EQ_RESTART_BIT    = 6;
  localparam int EQ_FLOOR_OVR_BIT  = 5;
  localparam int EQ_FLOOR_BIT      = 4;

  // Number of receive ports holding their own equalizer copy.
  localparam int NUM_PORTS = 2;

  // Receive input mode encodings.
  typedef enum logic [1:0] {
    DALC_MODE_AUTO        = 2'h0,
    DALC_MODE_DUAL        = 2'h1,
    DALC_MODE_SINGLE_PRI  = 2'h2,
    DALC_MODE_SINGLE_SEC  = 2'h3
  } dalc_input_mode_t;

endpackage : dalc_pkg

// >>> rtl/dalc_eq_if.sv
// Interface carrying equalizer register traffic between the register bank
// and the per-port equalizer copies. Assumes one clock for both ends.
`timescale 1ns/100ps
interface dalc_eq_if;
  import dalc_pkg::*;
  logic                 wr;        // Write strobe to the equalizer register.
  logic [7:0]           wdata;     // Write data.
  logic [NUM_PORTS-1:0] port_sel;  // Ports whose copy a write updates.
  logic                 rd_second; // Read back the second port copy.
  logic [7:0]           rdata;     // Read-back value of the chosen copy.
  logic [NUM_PORTS-1:0] restart;   // Restart bit of each copy.
  logic [NUM_PORTS-1:0] floor_eff; // Floor start gated by its override.

  modport bank (output wr, wdata, port_sel, rd_second,
                input  rdata, restart, floor_eff);
  modport copies (input  wr, wdata, port_sel, rd_second,
                  output rdata, restart, floor_eff);
endinterface : dalc_eq_if

// >>> rtl/dalc_eq_copies.sv
// Per-port copies of the equalizer test control register.
// Assumes writes arrive as one-cycle strobes on ref_clk.
`timescale 1ns/100ps
module dalc_eq_copies (
  // Clock and reset.
  input  wire logic ref_clk,
  input  wire logic srst,
  // Register traffic.
  dalc_eq_if.copies eq
);
  import dalc_pkg::*;

  logic [7:0] copy_r   [NUM_PORTS];
  logic [7:0] copy_nxt [NUM_PORTS];

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      // A write lands in every selected port's copy; reserved bits stay zero.
      always_comb begin
        copy_nxt[p] = copy_r[p];
        if (eq.wr && eq.port_sel[p]) begin
          copy_nxt[p] = '0;
          copy_nxt[p][EQ_RESTART_BIT]   = eq.wdata[EQ_RESTART_BIT];
          copy_nxt[p][EQ_FLOOR_OVR_BIT] = eq.wdata[EQ_FLOOR_OVR_BIT];
          copy_nxt[p][EQ_FLOOR_BIT]     = eq.wdata[EQ_FLOOR_BIT];
        end
      end

      always_ff @(posedge ref_clk) begin
        if (srst) begin
          copy_r[p] <= EQUALIZER_TEST_CONTROL_RST;
        end else begin
          copy_r[p] <= copy_nxt[p];
        end
      end

      // The floor only applies while its override is on.
      assign eq.floor_eff[p] = copy_r[p][EQ_FLOOR_OVR_BIT] &
                               copy_r[p][EQ_FLOOR_BIT];
      assign eq.restart[p]   = copy_r[p][EQ_RESTART_BIT];
    end
  endgenerate

  // The second port copy wins the read when it is selected.
  assign eq.rdata = eq.rd_second ? copy_r[1] : copy_r[0];

endmodule : dalc_eq_copies

// >>> rtl/dalc_regs.sv
// Audio, link and equalizer control register bank of the deserializer.
// Assumes the serial control port target presents one-cycle read and write
// strobes on ref_clk; FIFO events and link status come from ref_clk logic,
// the general pin comes straight from a pad.
`timescale 1ns/100ps

module dalc_regs (
  // Clock and reset.
  input  wire logic                      ref_clk,
  input  wire logic                      srst,
  // Register access from the serial control target.
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  input  wire logic [7:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  output logic      [7:0]                reg_rdata,
  output logic                           reg_rvalid,
  // Audio FIFO.
  input  wire logic                      fifo_overrun_evt,
  input  wire logic                      fifo_underrun_evt,
  output logic                           fifo_error_clear,
  output logic                           audio_sample_rising,
  // Pixel clock source.
  output logic                           pixel_clock_from_test,
  // Link lock.
  input  wire logic                      link_linked,
  input  wire logic                      video_off,
  output logic                           lock_out,
  // Back channel.
  input  wire logic                      general_pin_zero,
  input  wire logic                      filtered_backchannel,
  output logic                           backchannel_bit,
  // Receive configuration.
  output dalc_pkg::dalc_input_mode_t     receive_input_mode,
  output logic      [dalc_pkg::NUM_PORTS-1:0] port_select,
  // Adaptive equalizer controls, one bit per port.
  output logic      [dalc_pkg::NUM_PORTS-1:0] equalizer_restart,
  output logic      [dalc_pkg::NUM_PORTS-1:0] equalizer_floor_start
);
  import dalc_pkg::*;

  // Address match shared by the write and read decoders.
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    addr_hit = (addr == ofs);
  endfunction : addr_hit

  // Equalizer copies live in their own module.
  dalc_eq_if eq ();

  dalc_eq_copies u_eq_copies (
    .ref_clk (ref_clk),
    .srst    (srst),
    .eq      (eq)
  );

  // ------------------------------------------------------------------
  // Shared register state.
  // ------------------------------------------------------------------
  logic       overrun_r;
  logic       overrun_nxt;
  logic       underrun_r;
  logic       underrun_nxt;
  logic       err_clear_bit_r;
  logic       err_clear_bit_nxt;
  logic       edge_rising_r;
  logic       edge_rising_nxt;
  logic       pclk_test_r;
  logic       pclk_test_nxt;
  logic       lock_mode_r;
  logic       lock_mode_nxt;
  logic       raw_bc_r;
  logic       raw_bc_nxt;
  logic [1:0] input_mode_r;
  logic [1:0] input_mode_nxt;
  logic       sel_second_r;
  logic       sel_second_nxt;
  logic       sel_first_r;
  logic       sel_first_nxt;
  logic       err_clear_pulse_r;
  logic       err_clear_pulse_nxt;

  logic wr_audio;
  logic wr_pclk;
  logic wr_dual;
  logic wr_eq;
  logic err_clear_req;

  // Write decode for each register.
  assign wr_audio = reg_wr && addr_hit(reg_addr, AUDIO_SERIAL_CONTROL_OFS);
  assign wr_pclk  = reg_wr && addr_hit(reg_addr, PIXEL_CLOCK_TEST_SELECT_OFS);
  assign wr_dual  = reg_wr && addr_hit(reg_addr, DUAL_RECEIVE_CONTROL_OFS);
  assign wr_eq    = reg_wr && addr_hit(reg_addr, EQUALIZER_TEST_CONTROL_OFS);

  // Clearing acts on the write itself, not on the stored bit, so a stale 1
  // left in the clear bit never masks later errors.
  assign err_clear_req = wr_audio && reg_wdata[AUD_ERR_CLEAR_BIT];

  // Next values of the shared registers. A FIFO event in the same cycle as
  // a clear wins, so no error goes unseen.
  always_comb begin
    overrun_nxt         = overrun_r;
    underrun_nxt        = underrun_r;
    err_clear_bit_nxt   = err_clear_bit_r;
    edge_rising_nxt     = edge_rising_r;
    pclk_test_nxt       = pclk_test_r;
    lock_mode_nxt       = lock_mode_r;
    raw_bc_nxt          = raw_bc_r;
    input_mode_nxt      = input_mode_r;
    sel_second_nxt      = sel_second_r;
    sel_first_nxt       = sel_first_r;
    err_clear_pulse_nxt = err_clear_req;
    if (err_clear_req) begin
      overrun_nxt  = 1'b0;
      underrun_nxt = 1'b0;
    end
    if (fifo_overrun_evt) begin
      overrun_nxt = 1'b1;
    end
    if (fifo_underrun_evt) begin
      underrun_nxt = 1'b1;
    end
    if (wr_audio) begin
      err_clear_bit_nxt = reg_wdata[AUD_ERR_CLEAR_BIT];
      edge_rising_nxt   = reg_wdata[AUD_EDGE_BIT];
    end
    if (wr_pclk) begin
      pclk_test_nxt = reg_wdata[PCLK_TEST_BIT];
    end
    if (wr_dual) begin
      lock_mode_nxt  = reg_wdata[RX_LOCK_MODE_BIT];
      raw_bc_nxt     = reg_wdata[RAW_BACKCH_BIT];
      input_mode_nxt = reg_wdata[INPUT_MODE_HI_BIT:INPUT_MODE_LO_BIT];
      sel_second_nxt = reg_wdata[SECOND_PORT_BIT];
      sel_first_nxt  = reg_wdata[FIRST_PORT_BIT];
    end
  end

  // Shared registers take their documented reset values.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      overrun_r         <= AUDIO_SERIAL_CONTROL_RST[AUD_OVERRUN_BIT];
      underrun_r        <= AUDIO_SERIAL_CONTROL_RST[AUD_UNDERRUN_BIT];
      err_clear_bit_r   <= AUDIO_SERIAL_CONTROL_RST[AUD_ERR_CLEAR_BIT];
      edge_rising_r     <= AUDIO_SERIAL_CONTROL_RST[AUD_EDGE_BIT];
      pclk_test_r       <= PIXEL_CLOCK_TEST_SELECT_RST[PCLK_TEST_BIT];
      lock_mode_r       <= DUAL_RECEIVE_CONTROL_RST[RX_LOCK_MODE_BIT];
      raw_bc_r          <= DUAL_RECEIVE_CONTROL_RST[RAW_BACKCH_BIT];
      input_mode_r      <= DUAL_RECEIVE_CONTROL_RST[INPUT_MODE_HI_BIT:INPUT_MODE_LO_BIT];
      sel_second_r      <= DUAL_RECEIVE_CONTROL_RST[SECOND_PORT_BIT];
      sel_first_r       <= DUAL_RECEIVE_CONTROL_RST[FIRST_PORT_BIT];
      err_clear_pulse_r <= 1'b0;
    end else begin
      overrun_r         <= overrun_nxt;
      underrun_r        <= underrun_nxt;
      err_clear_bit_r   <= err_clear_bit_nxt;
      edge_rising_r     <= edge_rising_nxt;
      pclk_test_r       <= pclk_test_nxt;
      lock_mode_r       <= lock_mode_nxt;
      raw_bc_r          <= raw_bc_nxt;
      input_mode_r      <= input_mode_nxt;
      sel_second_r      <= sel_second_nxt;
      sel_first_r       <= sel_first_nxt;
      err_clear_pulse_r <= err_clear_pulse_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Equalizer copies: writes fan out to every selected port, reads favour
  // port 1. The host must drop the port-1 select to see port 0 again.
  // ------------------------------------------------------------------
  assign eq.wr        = wr_eq;
  assign eq.wdata     = reg_wdata;
  assign eq.port_sel  = {sel_second_r, sel_first_r};
  assign eq.rd_second = sel_second_r;

  // ------------------------------------------------------------------
  // Read path: one cycle of latency, unmapped offsets read as zero.
  // ------------------------------------------------------------------
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       rvalid_r;
  logic       rvalid_nxt;

  always_comb begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = reg_rd;
    if (reg_rd) begin
      rdata_nxt = 8'h00;
      if (addr_hit(reg_addr, AUDIO_SERIAL_CONTROL_OFS)) begin
        rdata_nxt[AUD_OVERRUN_BIT]   = overrun_r;
        rdata_nxt[AUD_UNDERRUN_BIT]  = underrun_r;
        rdata_nxt[AUD_ERR_CLEAR_BIT] = err_clear_bit_r;
        rdata_nxt[AUD_EDGE_BIT]      = edge_rising_r;
      end else if (addr_hit(reg_addr, PIXEL_CLOCK_TEST_SELECT_OFS)) begin
        rdata_nxt[PCLK_TEST_BIT] = pclk_test_r;
      end else if (addr_hit(reg_addr, DUAL_RECEIVE_CONTROL_OFS)) begin
        rdata_nxt[RX_LOCK_MODE_BIT]                    = lock_mode_r;
        rdata_nxt[RAW_BACKCH_BIT]                      = raw_bc_r;
        rdata_nxt[INPUT_MODE_HI_BIT:INPUT_MODE_LO_BIT] = input_mode_r;
        rdata_nxt[SECOND_PORT_BIT]                     = sel_second_r;
        rdata_nxt[FIRST_PORT_BIT]                      = sel_first_r;
      end else if (addr_hit(reg_addr, EQUALIZER_TEST_CONTROL_OFS)) begin
        rdata_nxt = eq.rdata;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // ------------------------------------------------------------------
  // General pin zero arrives from a pad, so it is synchronised first. The
  // raw path still adds these two flops but does no sampling or filtering.
  // ------------------------------------------------------------------
  logic gpin_meta_r;
  logic gpin_meta_nxt;
  logic gpin_sync_r;
  logic gpin_sync_nxt;

  always_comb begin
    gpin_meta_nxt = general_pin_zero;
    gpin_sync_nxt = gpin_meta_r;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      gpin_meta_r <= 1'b0;
      gpin_sync_r <= 1'b0;
    end else begin
      gpin_meta_r <= gpin_meta_nxt;
      gpin_sync_r <= gpin_sync_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Registered control outputs.
  // ------------------------------------------------------------------
  logic                 lock_r;
  logic                 lock_nxt;
  logic                 bc_r;
  logic                 bc_nxt;
  logic [NUM_PORTS-1:0] restart_r;
  logic [NUM_PORTS-1:0] restart_nxt;
  logic [NUM_PORTS-1:0] floor_r;
  logic [NUM_PORTS-1:0] floor_nxt;

  always_comb begin
    // Mode 1 reports lock on link alone; mode 0 also needs active video.
    if (lock_mode_r) begin
      lock_nxt = link_linked;
    end else begin
      lock_nxt = link_linked && !video_off;
    end
    bc_nxt = raw_bc_r ? gpin_sync_r : filtered_backchannel;
    // A restart held in either copy restarts adaptation on both ports.
    restart_nxt = {NUM_PORTS{|eq.restart}};
    floor_nxt   = eq.floor_eff;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lock_r    <= 1'b0;
      bc_r      <= 1'b0;
      restart_r <= '0;
      floor_r   <= '0;
    end else begin
      lock_r    <= lock_nxt;
      bc_r      <= bc_nxt;
      restart_r <= restart_nxt;
      floor_r   <= floor_nxt;
    end
  end

  // Every output comes from a flop above.
  assign reg_rdata             = rdata_r;
  assign reg_rvalid            = rvalid_r;
  assign fifo_error_clear      = err_clear_pulse_r;
  assign audio_sample_rising   = edge_rising_r;
  assign pixel_clock_from_test = pclk_test_r;
  assign lock_out              = lock_r;
  assign backchannel_bit       = bc_r;
  assign receive_input_mode    = dalc_input_mode_t'(input_mode_r);
  assign port_select           = {sel_second_r, sel_first_r};
  assign equalizer_restart     = restart_r;
  assign equalizer_floor_start = floor_r;

endmodule : dalc_regs

// >>> test/dalc_regs_monitor.sv
// Checker for the control register bank, watching only its top ports.
// Assumes one ref_clk domain and synchronous active-high srst.
`timescale 1ns/100ps
module dalc_regs_monitor (
  // Clock and reset.
  input wire logic                           ref_clk,
  input wire logic                           srst,
  // Register access.
  input wire logic                           reg_wr,
  input wire logic                           reg_rd,
  input wire logic [7:0]                     reg_addr,
  input wire logic [7:0]                     reg_wdata,
  input wire logic [7:0]                     reg_rdata,
  input wire logic                           reg_rvalid,
  // Status and control.
  input wire logic                           fifo_overrun_evt,
  input wire logic                           fifo_error_clear,
  input wire logic                           audio_sample_rising,
  input wire logic                           pixel_clock_from_test,
  input wire logic                           link_linked,
  input wire logic                           video_off,
  input wire logic                           lock_out,
  input wire dalc_pkg::dalc_input_mode_t     receive_input_mode,
  input wire logic [dalc_pkg::NUM_PORTS-1:0] port_select,
  input wire logic [dalc_pkg::NUM_PORTS-1:0] equalizer_restart
);
  import dalc_pkg::*;
  // Everything here lives on ref_clk and is void while srst is high.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Offsets outside this set must read back as zero.
  logic mapped;
  assign mapped = reg_addr inside {8'h2b, 8'h2e, 8'h34, 8'h35};

  rd_answer_a: assert property (reg_rvalid == $past(reg_rd))
    else $error("read answer not one cycle after the strobe");
  unmapped_zero_a: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  // A clear write between the event and the read may legally drop the flag.
  overrun_seen_a: assert property (fifo_overrun_evt ##1
    (!(reg_wr && reg_addr == 8'h2b) ##[0:1] (reg_rd && reg_addr == 8'h2b))
    |=> reg_rdata[3]) else $error("overrun flag not seen");
  err_clear_a: assert property (fifo_error_clear ==
    $past(reg_wr && reg_addr == 8'h2b && reg_wdata[1])) else $error("clear pulse wrong");
  edge_sel_a: assert property (reg_wr && reg_addr == 8'h2b
    |=> audio_sample_rising == $past(reg_wdata[0])) else $error("edge select wrong");
  pclk_sel_a: assert property (reg_wr && reg_addr == 8'h2e
    |=> pixel_clock_from_test == $past(reg_wdata[7])) else $error("pixel source wrong");
  no_link_a: assert property ((!link_linked)[*3] |-> !lock_out)
    else $error("lock without link");
  video_lock_a: assert property ((link_linked && !video_off)[*3] |-> lock_out)
    else $error("no lock with active video");
  mode_sel_a: assert property (reg_wr && reg_addr == 8'h34 |=>
    receive_input_mode == $past(reg_wdata[4:3]) && port_select == $past(reg_wdata[1:0]))
    else $error("receive control fields wrong");
  port_reset_a: assert property ($past(srst) |-> port_select == 2'b01)
    else $error("port selects wrong after reset");
  restart_both_a: assert property (equalizer_restart[0] == equalizer_restart[1])
    else $error("restart differs between ports");
  // A restart written through any selected port reaches both ports two edges on.
  restart_set_a: assert property (reg_wr && reg_addr == 8'h35 && reg_wdata[6] &&
    port_select != 2'b00 |-> ##2 equalizer_restart == 2'b11)
    else $error("restart not raised on both ports");
endmodule : dalc_regs_monitor

bind dalc_regs dalc_regs_monitor u_mon (.ref_clk, .srst, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rdata, .reg_rvalid, .fifo_overrun_evt, .fifo_error_clear,
  .audio_sample_rising, .pixel_clock_from_test, .link_linked, .video_off, .lock_out,
  .receive_input_mode, .port_select, .equalizer_restart);

// >>> test/dalc_host_model.sv
// Host model driving the serial control target's one-cycle strobes.
// Assumes a registered read answer within a few cycles of the strobe.
`timescale 1ns/100ps
module dalc_host_model (
  // Clock.
  input  wire logic       ref_clk,
  // Register access toward the bank.
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  // Idle lines carry junk so no stale value can pass for a real one.
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'ha5;
    reg_wdata = 8'h5a;
  end

  // One write strobe; address and data are scrambled once it is taken.
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= addr;
    reg_wdata <= data;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~addr;
    reg_wdata <= ~data;
  endtask : write_reg

  // One read strobe, then a bounded wait for the answer.
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    ok   = 1'b0;
    data = 8'h00;
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= addr;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~addr;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge ref_clk);
      if (reg_rvalid === 1'b1) begin
        ok   = 1'b1;
        data = reg_rdata;
      end
    end
  endtask : read_reg
endmodule : dalc_host_model

// >>> test/test_deser_audio_link_ctrl_regs.sv
// Self-checking bench for the audio, link and equalizer register bank.
// Assumes the host model drives all register strobes.
`timescale 1ns/100ps
module test_deser_audio_link_ctrl_regs;
  import dalc_pkg::*;
  logic             ref_clk = 1'b0;
  logic             srst = 1'b1;
  logic             ovr = 1'b0;
  logic             und = 1'b0;
  logic             linked = 1'b0;
  logic             vid_off = 1'b0;
  logic             gpin = 1'b0;
  logic             filt = 1'b0;
  logic             reg_wr, reg_rd, reg_rvalid, err_clr, edge_r, pclk, lock, bch;
  logic [7:0]       reg_addr, reg_wdata, reg_rdata, rd_data, v, a;
  logic             rd_ok;
  logic [2:0]       combo;
  logic [1:0]       port_sel, restart, floor_st;
  dalc_input_mode_t in_mode;
  integer           seed = 32'h7cc697f4;
  integer           n_mismatch = 0;
  integer           cmp_count = 0;

  always #5 ref_clk = ~ref_clk;

  dalc_host_model u_host (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));
  dalc_regs u_dut (.ref_clk(ref_clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .fifo_overrun_evt(ovr), .fifo_underrun_evt(und),
    .fifo_error_clear(err_clr), .audio_sample_rising(edge_r),
    .pixel_clock_from_test(pclk), .link_linked(linked), .video_off(vid_off),
    .lock_out(lock), .general_pin_zero(gpin), .filtered_backchannel(filt),
    .backchannel_bit(bch), .receive_input_mode(in_mode), .port_select(port_sel),
    .equalizer_restart(restart), .equalizer_floor_start(floor_st));

  // Writable bits that read back at each offset; unmapped offsets read nothing.
  function automatic logic [7:0] rw_mask(input logic [7:0] addr);
    case (addr)
      8'h2b:   rw_mask = 8'h03;
      8'h2e:   rw_mask = 8'h80;
      8'h34:   rw_mask = 8'h7b;
      8'h35:   rw_mask = 8'h70;
      default: rw_mask = 8'h00;
    endcase
  endfunction : rw_mask

  // Expected lock level from mode, link and video-off.
  function automatic logic lock_exp(input logic mode, input logic lnk, input logic off);
    lock_exp = lnk & (mode | ~off);
  endfunction : lock_exp

  task automatic print_verdict;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  // Write, then step to the falling edge so the taken edge has landed.
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    u_host.write_reg(addr, data);
    @(negedge ref_clk);
  endtask : wr

  // Compares a register read; a missing answer ends the run.
  task automatic chk_reg(input logic [7:0] addr, input logic [7:0] exp);
    u_host.read_reg(addr, rd_data, rd_ok);
    cmp_count++;
    if (rd_ok !== 1'b1 || rd_data !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t read %h got %h want %h", $time, addr, rd_data, exp);
      if (rd_ok !== 1'b1) print_verdict();
    end
  endtask : chk_reg

  // Compares a control output.
  task automatic chk_out(input logic [1:0] got, input logic [1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t output got %h want %h", $time, got, exp);
    end
  endtask : chk_out

  initial begin
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    chk_out(port_sel, 2'b01);
    chk_reg(8'h2b, 8'h00);
    chk_reg(8'h2e, 8'h00);
    chk_reg(8'h34, 8'h01);
    chk_reg(8'h35, 8'h00);
    chk_reg(8'h40, 8'h00);
    // Random bytes, status and reserved bits included, come back masked.
    for (int i = 0; i < 16; i++) begin
      v = $random(seed);
      a = (i % 4 == 0) ? 8'h2b : (i % 4 == 1) ? 8'h2e : (i % 4 == 2) ? 8'h35 : 8'h6c;
      wr(a, v);
      if (a == 8'h2e) chk_out({1'b0, pclk}, {1'b0, v[7]});
      if (a == 8'h2b) chk_out({1'b0, edge_r}, {1'b0, v[0]});
      chk_reg(a, v & rw_mask(a));
    end
    for (int m = 0; m < 4; m++) begin
      wr(8'h34, {3'h0, m[1:0], 3'h1});
      chk_out(in_mode, m[1:0]);
    end
    // Flags latch on one-cycle events and hold until a clear write.
    wr(8'h2b, 8'h01);
    @(posedge ref_clk) ovr <= 1'b1;
    @(posedge ref_clk) ovr <= 1'b0;
    chk_reg(8'h2b, 8'h09);
    repeat (20) @(posedge ref_clk);
    chk_reg(8'h2b, 8'h09);
    @(posedge ref_clk) und <= 1'b1;
    @(posedge ref_clk) und <= 1'b0;
    chk_reg(8'h2b, 8'h0d);
    wr(8'h2b, 8'h03);
    chk_out({1'b0, err_clr}, 2'b01);
    chk_reg(8'h2b, 8'h03);
    // A clear write and an overrun in one cycle: the event wins.
    fork
      u_host.write_reg(8'h2b, 8'h03);
      @(posedge ref_clk) ovr <= 1'b1;
    join
    ovr <= 1'b0;
    chk_reg(8'h2b, 8'h0b);
    wr(8'h2b, 8'h01);
    // Every lock mode, link and video-off combination.
    for (int c = 0; c < 8; c++) begin
      combo = c[2:0];
      wr(8'h34, {1'b0, combo[2], 6'h01});
      @(posedge ref_clk) begin
        linked  <= combo[1];
        vid_off <= combo[0];
      end
      repeat (3) @(posedge ref_clk);
      #1 chk_out({1'b0, lock}, {1'b0, lock_exp(combo[2], combo[1], combo[0])});
    end
    // Raw back channel follows the pin; otherwise the filtered bit.
    for (int i = 0; i < 6; i++) begin
      if (i % 3 == 0) wr(8'h34, (i == 0) ? 8'h21 : 8'h01);
      v = $random(seed);
      @(posedge ref_clk) begin
        gpin <= v[0];
        filt <= ~v[0];
      end
      repeat (5) @(posedge ref_clk);
      #1 chk_out({1'b0, bch}, {1'b0, (i < 3) ? v[0] : ~v[0]});
    end
    // Port steering of the equalizer copies; port 0 first drops its random byte.
    wr(8'h35, 8'h00);
    wr(8'h34, 8'h02);
    wr(8'h35, 8'h30);
    repeat (2) @(posedge ref_clk);
    #1 chk_out(floor_st, 2'b10);
    wr(8'h34, 8'h03);
    chk_reg(8'h35, 8'h30);
    wr(8'h35, 8'h20);
    repeat (2) @(posedge ref_clk);
    #1 chk_out(floor_st, 2'b00);
    wr(8'h34, 8'h01);
    wr(8'h35, 8'h10);
    chk_reg(8'h35, 8'h10);
    chk_out(floor_st, 2'b00);
    wr(8'h35, 8'h30);
    repeat (2) @(posedge ref_clk);
    #1 chk_out(floor_st, 2'b01);
    wr(8'h34, 8'h03);
    chk_reg(8'h35, 8'h20);
    // Restart is written high then low through port 0 alone.
    wr(8'h34, 8'h01);
    wr(8'h35, 8'h70);
    repeat (2) @(posedge ref_clk);
    #1 chk_out(restart, 2'b11);
    wr(8'h35, 8'h30);
    repeat (2) @(posedge ref_clk);
    #1 chk_out(restart, 2'b00);
    print_verdict();
  end
endmodule : test_deser_audio_link_ctrl_regs
